//--- hw/odr_pkg.sv
// Package of constants and types for the octal register block
package odr_pkg;
  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ODR_WIDTH = 8;
  // ------------------------------------------------------------
  // APB register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] ODR_CTRL_ADDR = 12'h000;
  localparam logic [11:0] ODR_DATA_ADDR = 12'h004;
  localparam logic [11:0] ODR_STAT_ADDR = 12'h008;
  localparam logic [11:0] ODR_ID_ADDR = 12'h00C;
  // ------------------------------------------------------------
  // Control register field positions and reset value
  // ------------------------------------------------------------
  localparam int ODR_CTRL_SW_CLEAR_BIT = 0;
  localparam int ODR_CTRL_SW_HOLD_BIT = 1;
  localparam int ODR_CTRL_SW_FLOAT_BIT = 2;
  localparam logic [2:0] ODR_CTRL_RST = 3'h0;
  // ------------------------------------------------------------
  // Status register field positions
  // ------------------------------------------------------------
  localparam int ODR_STAT_DRIVE_BIT = 0;
  localparam int ODR_STAT_CLEAR_BIT = 1;
  localparam int ODR_STAT_LOAD_BIT = 2;
  // Identity value, arbitrary
  localparam logic [31:0] ODR_ID_VALUE = 32'h0000_0A5A;
  // Reset value of the stored byte
  localparam logic [7:0] ODR_STORE_RST = 8'h00;
  // ------------------------------------------------------------
  // Operating mode of the store
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ODR_MODE_CLEAR = 3'b001,
    ODR_MODE_HOLD = 3'b010,
    ODR_MODE_LOAD = 3'b100
  } odr_mode_t;
endpackage

//--- hw/odr_ctl_if.sv
// Interface carrying the control lines from top to store module
`timescale 1ns/1ps
interface odr_ctl_if;
  logic zeroAll; // Active high clear request
  logic load; // Active high load request
  logic [7:0] dataIn; // Synchronised input byte
  logic [7:0] stored; // Stored byte
  modport ctl (output zeroAll, output load, output dataIn, input stored);
  modport store (input zeroAll, input load, input dataIn, output stored);
endinterface // odr_ctl_if

//--- hw/odr_store.sv
// Eight-bit store with clear priority over load
`timescale 1ns/1ps
module odr_store
  import odr_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  odr_ctl_if.store ctl // Control and data lines
);
  logic [7:0] store_q;
  logic [7:0] store_d;

  // Next value per bit; one loop serves all eight
  for (genvar i = 0; i < ODR_WIDTH; i++)
  begin : g_bit
    always_comb
    begin
      if (ctl.zeroAll)
        store_d[i] = 1'b0;
      else if (ctl.load)
        store_d[i] = ctl.dataIn[i];
      else
        store_d[i] = store_q[i];
    end
  end

  // Registered store; output gating never reaches it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      store_q <= ODR_STORE_RST;
    else
      store_q <= store_d;
  end

  assign ctl.stored = store_q;
endmodule // odr_store

//--- hw/odr_octal_reg.sv
// Top of the octal clearable register with gated bus drive
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module odr_octal_reg
  import odr_pkg::*;
#(
  parameter int WIDTH = 8 // Data width
)
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [7:0] data_in, // Data pins
  input wire logic load_enable_n, // Load enable pin, active low
  input wire logic zero_all_n, // Clear pin, active low
  input wire logic drive_gate_1_n, // Drive gate 1, active low
  input wire logic drive_gate_2_n, // Drive gate 2, active low
  input wire logic drive_gate_3_n, // Drive gate 3, active low
  output logic [7:0] data_out, // Output data value
  output logic [7:0] data_out_oe, // Output enable per bit, high drives
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error
);
  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (WIDTH != ODR_WIDTH)
  begin : g_bad_width
    $error("odr_octal_reg supports only eight bits");
  end

  // ------------------------------------------------------------
  // Pin synchronisers: three stages, accept on stage 2/3 agreement
  // ------------------------------------------------------------
  // Positions of the control pins inside the pin word
  localparam int PIN_LOAD = 8;
  localparam int PIN_CLEAR = 9;
  localparam int PIN_GATE1 = 10;
  localparam int PIN_GATE3 = 12;
  localparam int NPIN = 13;
  // Idle pin levels: gates, clear and load enable high, data low
  localparam logic [NPIN-1:0] SYNC_IDLE = 13'h1F00;
  // The pin word must hold the data pins and the five control pins
  if (NPIN != ODR_WIDTH + 5 || PIN_GATE3 != NPIN - 1)
  begin : g_bad_npin
    $error("odr_octal_reg pin word does not match the pin list");
  end
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
  logic [NPIN-1:0] s1_d, s2_d, s3_d, pin_d;
  assign pinRaw = {drive_gate_3_n, drive_gate_2_n, drive_gate_1_n,
                   zero_all_n, load_enable_n, data_in};

  // Accepted pin levels under their own names
  logic [7:0] dataSync;
  logic loadSyncN;
  logic clearSyncN;
  logic [2:0] gateSyncN;
  assign dataSync = pin_q[PIN_LOAD-1:0];
  assign loadSyncN = pin_q[PIN_LOAD];
  assign clearSyncN = pin_q[PIN_CLEAR];
  assign gateSyncN = pin_q[PIN_GATE3:PIN_GATE1];

  // Stage chain; stage 1 feeds only stage 2
  always_comb
  begin
    s1_d = pinRaw;
    s2_d = s1_q;
    s3_d = s2_q;
    pin_d = pin_q;
    for (int i = 0; i < NPIN; i++)
    begin
      if (s2_q[i] == s3_q[i])
        pin_d[i] = s3_q[i];
    end
  end

  // Inactive levels at reset: gates and clear high, load off
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
      s3_q <= SYNC_IDLE;
      pin_q <= SYNC_IDLE;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      pin_q <= pin_d;
    end
  end

  // ------------------------------------------------------------
  // APB control register
  // ------------------------------------------------------------
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic err_q;
  logic err_d;
  logic access;
  logic [7:0] storedByte;
  logic gatesOpen;
  odr_mode_t mode;
  logic [31:0] statusWord;
  assign access = psel && penable;

  // Status word assembled from its field positions
  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[ODR_STAT_DRIVE_BIT] = gatesOpen;
    statusWord[ODR_STAT_CLEAR_BIT] = (mode == ODR_MODE_CLEAR);
    statusWord[ODR_STAT_LOAD_BIT] = (mode == ODR_MODE_LOAD);
  end

  // Decode; unmapped addresses answer with pslverr and zero data
  // Read data is taken in the setup cycle, so the access cycle only shows it
  // Writes to read-only words are dropped without an error
  always_comb
  begin
    ctrl_d = ctrl_q;
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (psel && !penable)
    begin
      if (paddr == ODR_CTRL_ADDR)
        rdata_d = {29'h0, ctrl_q};
      else if (paddr == ODR_DATA_ADDR)
        rdata_d = {24'h0, storedByte};
      else if (paddr == ODR_STAT_ADDR)
        rdata_d = statusWord;
      else if (paddr == ODR_ID_ADDR)
        rdata_d = ODR_ID_VALUE;
      else
        err_d = 1'b1;
    end
    else
    begin
      rdata_d = rdata_q;
      err_d = err_q;
    end
    if (access && pwrite && paddr == ODR_CTRL_ADDR)
      ctrl_d = pwdata[2:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= ODR_CTRL_RST;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // Single access cycle, so ready is always high
  assign pready = 1'b1;
  // Masked outside a read so an idle bus sees zero
  assign prdata = (access && !pwrite) ? rdata_q : 32'h0000_0000;
  assign pslverr = access && err_q;

  // ------------------------------------------------------------
  // Mode selection and store
  // ------------------------------------------------------------
  // Clear first, then load unless held, else hold; the software bits act like the pins
  always_comb
  begin
    if (!clearSyncN || ctrl_q[ODR_CTRL_SW_CLEAR_BIT])
      mode = ODR_MODE_CLEAR;
    else if (!loadSyncN && !ctrl_q[ODR_CTRL_SW_HOLD_BIT])
      mode = ODR_MODE_LOAD;
    else
      mode = ODR_MODE_HOLD;
  end

  odr_ctl_if ctlBus();
  assign ctlBus.zeroAll = (mode == ODR_MODE_CLEAR);
  assign ctlBus.load = (mode == ODR_MODE_LOAD);
  assign ctlBus.dataIn = dataSync;
  assign storedByte = ctlBus.stored;

  odr_store u_store
  (
    .clk(clk),
    .rst(rst),
    .ctl(ctlBus)
  );

  // ------------------------------------------------------------
  // Output drive: one gate term shared by all bits
  // ------------------------------------------------------------
  // Gates touch only the enables and the status drive bit, never the store
  assign gatesOpen = (gateSyncN == 3'h0)
                     && !ctrl_q[ODR_CTRL_SW_FLOAT_BIT];
  // The store stays visible while floating; only the enables change
  assign data_out = storedByte;
  assign data_out_oe = gatesOpen ? 8'hFF : 8'h00;
endmodule // odr_octal_reg

//--- tb/odr_bus_model.sv
// Shared parallel bus seen by the register outputs
`timescale 1ns/1ps
module odr_bus_model
(
  input wire logic clk, // Clock
  input wire logic [7:0] driveVal, // Value offered
  input wire logic [7:0] driveEn, // High drives
  output logic [7:0] busLevel // Level on the bus
);
  logic [7:0] lastQ;
  // Remember the last driven byte
  always_ff @(posedge clk)
    if (driveEn == 8'hFF)
      lastQ <= driveVal;
  // Released bus has no keeper, so show the inverse
  assign busLevel = (driveEn == 8'hFF) ? driveVal : ~lastQ;
endmodule // odr_bus_model

//--- tb/odr_checker.sv
// Port checker of the octal register
`timescale 1ns/1ps
module odr_checker
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] data_in, // Data pins
  input wire logic load_enable_n, // Load enable
  input wire logic zero_all_n, // Clear
  input wire logic drive_gate_1_n, // Gate 1
  input wire logic drive_gate_2_n, // Gate 2
  input wire logic drive_gate_3_n, // Gate 3
  input wire logic [7:0] data_out, // Stored byte
  input wire logic [7:0] data_out_oe, // Drive enables
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata // Read data
);
  import odr_pkg::*;
  logic [2:0] ctrlQ;
  logic [2:0] ctrlD;
  logic [2:0] gates;
  assign gates = {drive_gate_3_n, drive_gate_2_n, drive_gate_1_n};
  // Shadow of the control word, so software overrides do not trip pin checks
  always_comb
    ctrlD = (psel && penable && pwrite && paddr == ODR_CTRL_ADDR) ? pwdata[2:0] : ctrlQ;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ctrlQ <= ODR_CTRL_RST;
    else
      ctrlQ <= ctrlD;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Windows long enough to cover the pin synchronisers
  sequence sOff; (gates != 3'h0 && $stable(gates))[*7]; endsequence
  sequence sOn; (gates == 3'h0 && !ctrlQ[2] && $stable(ctrlQ))[*7]; endsequence
  sequence sClr; (!zero_all_n)[*7]; endsequence
  sequence sLoad; (zero_all_n && !load_enable_n && ctrlQ[1:0] == 2'h0
    && $stable({data_in, zero_all_n, load_enable_n, ctrlQ}))[*7]; endsequence
  sequence sHold; (zero_all_n && load_enable_n && !ctrlQ[0]
    && $stable({zero_all_n, load_enable_n, ctrlQ}))[*7]; endsequence
  AST_OE_UNIFORM: assert property (data_out_oe == 8'h00 || data_out_oe == 8'hFF)
    else $error("drive enables split");
  AST_FLOAT: assert property (sOff |-> data_out_oe == 8'h00)
    else $error("outputs not floating");
  AST_DRIVE: assert property (sOn |-> data_out_oe == 8'hFF)
    else $error("outputs not driving");
  AST_CLEAR: assert property (sClr |-> data_out == 8'h00)
    else $error("clear not applied");
  AST_LOAD: assert property (sLoad |-> data_out == data_in)
    else $error("load missed");
  AST_HOLD: assert property (sHold |-> $stable(data_out))
    else $error("hold broken");
  AST_RISE: assert property (($changed(data_out) && data_out != 8'h00) |->
    ($past(zero_all_n, 4) || $past(zero_all_n, 5) || $past(zero_all_n, 6)))
    else $error("load while clear low");
  AST_READ: assert property ((psel && penable && !pwrite && paddr == ODR_DATA_ADDR) |->
    prdata == {24'h0, $past(data_out)})
    else $error("read byte wrong");
endmodule // odr_checker
bind odr_octal_reg odr_checker chk (.clk, .rst, .data_in, .load_enable_n, .zero_all_n,
  .drive_gate_1_n, .drive_gate_2_n, .drive_gate_3_n, .data_out, .data_out_oe,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata);

//--- tb/odr_octal_reg_tb.sv
// Self-checking bench of the octal register
`timescale 1ns/1ps
`define CHK(n, e, s) begin checksDone++; if ((s) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module odr_octal_reg_tb;
  import odr_pkg::*;
  logic clk = 0, rst = 1, lden = 1, clrn = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [2:0] gate = 3'h7;
  logic [7:0] din = 8'h00, dout, oe, bus, exp = ODR_STORE_RST;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr;
  int errors = 0, checksDone = 0;
  always #5 clk = ~clk;
  odr_octal_reg dut (.clk, .rst, .data_in(din), .load_enable_n(lden), .zero_all_n(clrn),
    .drive_gate_1_n(gate[0]), .drive_gate_2_n(gate[1]), .drive_gate_3_n(gate[2]),
    .data_out(dout), .data_out_oe(oe), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  odr_bus_model busm (.clk, .driveVal(dout), .driveEn(oe), .busLevel(bus));
  // Verdict
  task final_report;
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    `CHK("ready", 1'b1, pready)
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Stored byte after one settled set of pins
  function logic [7:0] nxt(input logic [7:0] c, input logic [7:0] d, input logic en, cl);
    return !cl ? 8'h00 : (en ? c : d);
  endfunction
  // Apply pins, let the synchronisers settle, then compare
  task step(input logic [7:0] d, input logic en, cl, input logic [2:0] g);
    din <= d;
    lden <= en;
    clrn <= cl;
    gate <= g;
    exp = nxt(exp, d, en, cl);
    repeat (9) @(posedge clk);
    `CHK("store", exp, dout)
    `CHK("enable", (g == 3'h0) ? 8'hFF : 8'h00, oe)
    if (g == 3'h0) `CHK("bus", exp, bus)
  endtask
  initial
  begin
    void'($urandom(32'h44bb12ea));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    step(8'hFF, 0, 1, 3'h1);
    step(8'h5A, 0, 0, 3'h0);
    step(8'hA5, 1, 1, 3'h0);
    step(8'h3C, 0, 1, 3'h4);
    step(8'h00, 1, 1, 3'h0);
    repeat (40) step(8'($urandom), $urandom % 4 == 0, $urandom % 5 != 0,
      ($urandom % 2) ? 3'h0 : 3'($urandom));
    step(8'h77, 0, 1, 3'h0);
    apb(0, ODR_ID_ADDR, 0);
    `CHK("id", ODR_ID_VALUE, rd)
    apb(1, ODR_CTRL_ADDR, 32'h4);
    repeat (9) @(posedge clk);
    `CHK("float", 8'h00, oe)
    `CHK("keep", 8'h77, dout)
    apb(0, ODR_CTRL_ADDR, 0);
    `CHK("ctrl", 32'h4, rd)
    apb(1, ODR_CTRL_ADDR, 32'h1);
    repeat (9) @(posedge clk);
    apb(0, ODR_DATA_ADDR, 0);
    `CHK("swclr", 32'h0, rd)
    apb(0, ODR_STAT_ADDR, 0);
    `CHK("statclr", (32'h1 << ODR_STAT_DRIVE_BIT) | (32'h1 << ODR_STAT_CLEAR_BIT), rd)
    apb(1, ODR_CTRL_ADDR, 32'h0);
    repeat (9) @(posedge clk);
    apb(0, ODR_DATA_ADDR, 0);
    `CHK("reload", 32'h77, rd)
    apb(1, ODR_CTRL_ADDR, 32'h2);
    din <= 8'hC3;
    repeat (9) @(posedge clk);
    apb(0, ODR_DATA_ADDR, 0);
    `CHK("swhold", 32'h77, rd)
    apb(0, ODR_STAT_ADDR, 0);
    `CHK("stathold", 32'h1 << ODR_STAT_DRIVE_BIT, rd)
    apb(1, ODR_CTRL_ADDR, 32'h0);
    apb(0, ODR_STAT_ADDR, 0);
    `CHK("statload", (32'h1 << ODR_STAT_DRIVE_BIT) | (32'h1 << ODR_STAT_LOAD_BIT), rd)
    apb(0, ODR_DATA_ADDR, 0);
    `CHK("unhold", 32'hC3, rd)
    apb(1, 12'h010, 32'hFF);
    `CHK("slverr", 1'b1, err)
    final_report;
  end
  // Watchdog against a hang
  initial
  begin
    #50us;
    errors++;
    final_report;
  end
endmodule // odr_octal_reg_tb
